// *** src/csm_sync_mode_regs.sv ***
// Chip sync mode, channel mode and decimation registers with their effects
//
// Notes on behaviour
// [R1] In divider-reset mode each captured strobe resets every internal clock divider.
// [R2] In divider-reset mode a strobe that moves any divider phase drops the serial link.
// [R3] In timestamp mode strobes leave the dividers running untouched.
// [R4] In timestamp mode neither the link nor the signal monitor reacts to strobes.
// [R5] In timestamp mode the sample present at capture is tagged and the tag follows it.
// [R6] The tag travels as a control bit beside its sample in the link output word.
// [R7] Channel mode bit 5 set drops the quadrature part, clear keeps both parts.
// [R8] Application code 0000 is full bandwidth (default), 0001 enables converter 0 only.
// [R9] Application code 0010 enables converters 0 and 1, 0011 enables all four.
// [R10] Decimation codes 0000, 0001, 1000, 0010, 0101 give ratios 1, 2, 3, 4, 5.
// [R11] Software writes only listed codes; other codes are reserved and undefined.
//
// Implementation choice: the AHB-Lite interface to the registers.
`default_nettype none
`include "csm_consts.svh"

module csm_sync_mode_regs
  import csm_pkg::*;
#(
  parameter int SAMPLE_W     = 14,
  parameter int PIPE_DEPTH   = `CSM_TAG_PIPE_DEPTH,
  parameter int LINK_RECOVER = `CSM_LINK_RECOVER_CYC,
  parameter int DIV_W        = `CSM_DIV_WIDTH
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  // Frame alignment strobe pin
  input  wire logic                sysrefPin,
  // Converter samples
  input  wire logic                sampleValid,
  input  wire logic [SAMPLE_W-1:0] sampleI,
  input  wire logic [SAMPLE_W-1:0] sampleQ,
  // Link output word
  output logic                     linkValid,
  output logic [SAMPLE_W-1:0]      linkI,
  output logic [SAMPLE_W-1:0]      linkQ,
  output logic                     linkTag,
  output logic                     linkUp,
  // Clock divider and monitor effects
  output logic [DIV_W-1:0]         divPhase,
  output logic                     divReset,
  output logic                     monRestart,
  // Decoded configuration
  output logic [3:0]               ddcEnable,
  output logic                     ddcBypass,
  output logic                     qIgnore,
  output logic [2:0]               decimFactor
);

  // Register storage
  logic [7:0] syncModeReg;
  logic [7:0] chanModeReg;
  logic [7:0] decimReg;
  logic [7:0] capPhase;
  logic [7:0] strobeCount;

  // Bus data phase state
  logic       dpValid;
  logic       dpWrite;
  logic [11:0] dpIndex;

  // Strobe synchroniser and edge
  logic       sysrefMeta;
  logic       sysrefSync;
  logic       sysrefLast;

  // Link recovery state
  csm_link_state_t linkState;
  csm_link_state_t next_linkState;
  logic [15:0]     recoverCnt;

  // Tag pipeline storage
  logic [PIPE_DEPTH-1:0] pipeValid;
  logic [PIPE_DEPTH-1:0] pipeTag;
  logic [SAMPLE_W-1:0]   pipeI [PIPE_DEPTH];
  logic [SAMPLE_W-1:0]   pipeQ [PIPE_DEPTH];

  // Decode of a word index from a byte address
  function automatic logic [11:0] idxOf(input logic [31:0] addr);
    return addr[13:2];
  endfunction

  // Address phase decode
  wire        addrPhase = hsel & htrans[1] & hready;
  wire        wrStrobe  = dpValid & dpWrite;
  wire        wrSync    = wrStrobe & (dpIndex == `CSM_IDX_SYNC_MODE);
  wire        wrChan    = wrStrobe & (dpIndex == `CSM_IDX_CHANNEL_MODE);
  wire        wrDecim   = wrStrobe & (dpIndex == `CSM_IDX_DECIM_RATIO);
  wire [7:0]  wrByte    = hwdata[7:0];

  // Sync mode decode
  wire csm_sync_mode_t syncMode = syncModeReg[`CSM_SYNC_MODE_BIT] ?
                                  CSM_SYNC_TIMESTAMP : CSM_SYNC_DIVRESET;
  wire        strobeEdge = sysrefSync & ~sysrefLast;
  wire        divMode    = (syncMode == CSM_SYNC_DIVRESET);
  wire        phaseMoves = (divPhase != '0);
  wire [3:0]  appMode    = chanModeReg[`CSM_APP_MODE_MSB:0];
  wire [3:0]  decimCode  = decimReg[`CSM_DECIM_MSB:0];

  // Bus response, always ready and OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Read mux; unmapped indexes read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dpValid && !dpWrite) begin
      unique case (dpIndex)
        `CSM_IDX_SYNC_MODE:    hrdata = {24'h00_0000, syncModeReg};
        `CSM_IDX_CHANNEL_MODE: hrdata = {24'h00_0000, chanModeReg};
        `CSM_IDX_DECIM_RATIO:  hrdata = {24'h00_0000, decimReg};
        `CSM_IDX_SYNC_STATUS:  hrdata = {15'h0000, linkUp, strobeCount, capPhase};
        default:               hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Address phase capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpIndex <= 12'h000;
    end else if (hready) begin
      dpValid <= addrPhase;
      dpWrite <= hwrite;
      dpIndex <= idxOf(haddr);
    end
  end

  // Configuration registers, reserved bits held at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncModeReg <= `CSM_SYNC_MODE_RST;
      chanModeReg <= `CSM_CHANNEL_MODE_RST;
      decimReg    <= `CSM_DECIM_RATIO_RST;
    end else begin
      if (wrSync) syncModeReg <= wrByte & `CSM_SYNC_MODE_MASK;
      if (wrChan) chanModeReg <= wrByte & `CSM_CHANNEL_MODE_MASK;
      if (wrDecim) decimReg <= wrByte & `CSM_DECIM_RATIO_MASK;
    end
  end

  // Two-flop strobe synchroniser, then edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sysrefMeta <= 1'b0;
      sysrefSync <= 1'b0;
      sysrefLast <= 1'b0;
    end else begin
      sysrefMeta <= sysrefPin;
      sysrefSync <= sysrefMeta;
      sysrefLast <= sysrefSync;
    end
  end

  // Internal clock divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divPhase <= '0;
      divReset <= 1'b0;
    end else begin
      divReset <= 1'b0;
      // [R1] divider reset on strobe
      if (strobeEdge && divMode) begin
        divPhase <= '0;
        divReset <= 1'b1;
      end else begin
        // [R3] timestamp keeps dividers running
        divPhase <= divPhase + 1'b1;
      end
    end
  end

  // Signal monitor restart follows divider resets only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      monRestart <= 1'b0;
    end else begin
      // [R4] monitor ignores timestamp strobes
      monRestart <= strobeEdge & divMode;
    end
  end

  // Captured divider phase and strobe count for status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capPhase    <= 8'h00;
      strobeCount <= 8'h00;
    end else if (strobeEdge) begin
      capPhase    <= 8'(divPhase);
      strobeCount <= strobeCount + 8'h01;
    end
  end

  // Link state next value
  always_comb begin
    next_linkState = linkState;
    unique case (linkState)
      CSM_LINK_UP: begin
        // [R2] phase move drops link
        if (strobeEdge && divMode && phaseMoves) next_linkState = CSM_LINK_RECOVER;
      end
      CSM_LINK_RECOVER: begin
        if (recoverCnt == 16'(LINK_RECOVER - 1)) next_linkState = CSM_LINK_UP;
      end
    endcase
  end

  // Link state and recovery counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      linkState  <= CSM_LINK_UP;
      recoverCnt <= 16'h0000;
    end else begin
      linkState  <= next_linkState;
      recoverCnt <= (linkState == CSM_LINK_RECOVER) ? recoverCnt + 16'h0001 : 16'h0000;
    end
  end

  // [R4] link untouched in timestamp mode
  assign linkUp = (linkState == CSM_LINK_UP);

  // Tag pipeline entry stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pipeValid[0] <= 1'b0;
      pipeTag[0]   <= 1'b0;
      pipeI[0]     <= '0;
      pipeQ[0]     <= '0;
    end else begin
      pipeValid[0] <= sampleValid;
      // [R5] tag sample at capture
      pipeTag[0]   <= sampleValid & strobeEdge & ~divMode;
      pipeI[0]     <= sampleI;
      // [R7] quadrature dropped when set
      pipeQ[0]     <= qIgnore ? '0 : sampleQ;
    end
  end

  // Tag pipeline, tag follows its sample
  for (genvar s = 1; s < PIPE_DEPTH; s++) begin : gStage
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pipeValid[s] <= 1'b0;
        pipeTag[s]   <= 1'b0;
        pipeI[s]     <= '0;
        pipeQ[s]     <= '0;
      end else begin
        pipeValid[s] <= pipeValid[s-1];
        pipeTag[s]   <= pipeTag[s-1];
        pipeI[s]     <= pipeI[s-1];
        pipeQ[s]     <= pipeQ[s-1];
      end
    end
  end

  // Link output word from the last stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      linkValid <= 1'b0;
      linkI     <= '0;
      linkQ     <= '0;
      linkTag   <= 1'b0;
    end else begin
      linkValid <= pipeValid[PIPE_DEPTH-1] & linkUp;
      linkI     <= pipeI[PIPE_DEPTH-1];
      linkQ     <= pipeQ[PIPE_DEPTH-1];
      // [R6] tag as control bit
      linkTag   <= pipeTag[PIPE_DEPTH-1];
    end
  end

  // Quadrature handling select
  assign qIgnore = chanModeReg[`CSM_Q_IGNORE_BIT];

  // Converter enables from application mode
  always_comb begin
    ddcEnable = 4'b0000;
    unique case (appMode)
      // [R8] full bandwidth and one converter
      `CSM_APP_FULL_BW:  ddcEnable = 4'b0000;
      `CSM_APP_ONE_DDC:  ddcEnable = 4'b0001;
      // [R9] two and four converters
      `CSM_APP_TWO_DDC:  ddcEnable = 4'b0011;
      `CSM_APP_FOUR_DDC: ddcEnable = 4'b1111;
      // [R11] reserved codes fall back
      default:           ddcEnable = 4'b0000;
    endcase
  end

  // Decimation factor from ratio code
  always_comb begin
    decimFactor = 3'd1;
    unique case (decimCode)
      // [R10] listed ratios one to five
      `CSM_DEC_BY1: decimFactor = 3'd1;
      `CSM_DEC_BY2: decimFactor = 3'd2;
      `CSM_DEC_BY3: decimFactor = 3'd3;
      `CSM_DEC_BY4: decimFactor = 3'd4;
      `CSM_DEC_BY5: decimFactor = 3'd5;
      default:      decimFactor = 3'd1;
    endcase
  end

  // Bypass when no decimation
  assign ddcBypass = (decimFactor == 3'd1);

endmodule
`default_nettype wire

// *** src/csm_consts.svh ***
// Register map, field positions and reset values for chip sync and mode config
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH

// Register indexes; byte address is four times the index
`define CSM_IDX_SYNC_MODE     12'h01FF
`define CSM_IDX_CHANNEL_MODE  12'h0200
`define CSM_IDX_DECIM_RATIO   12'h0201
`define CSM_IDX_SYNC_STATUS   12'h0202

// Field positions
`define CSM_SYNC_MODE_BIT     0
`define CSM_Q_IGNORE_BIT      5
`define CSM_APP_MODE_MSB      3
`define CSM_DECIM_MSB         3

// Reset values and writable masks
`define CSM_SYNC_MODE_RST     8'h00
`define CSM_CHANNEL_MODE_RST  8'h00
`define CSM_DECIM_RATIO_RST   8'h00
`define CSM_SYNC_MODE_MASK    8'h01
`define CSM_CHANNEL_MODE_MASK 8'h2F
`define CSM_DECIM_RATIO_MASK  8'h0F

// Application mode codes
`define CSM_APP_FULL_BW       4'h0
`define CSM_APP_ONE_DDC       4'h1
`define CSM_APP_TWO_DDC       4'h2
`define CSM_APP_FOUR_DDC      4'h3

// Decimation codes
`define CSM_DEC_BY1           4'h0
`define CSM_DEC_BY2           4'h1
`define CSM_DEC_BY3           4'h8
`define CSM_DEC_BY4           4'h2
`define CSM_DEC_BY5           4'h5

// Timing counts in sample clocks and the divider width in bits
`define CSM_LINK_RECOVER_CYC  16
`define CSM_TAG_PIPE_DEPTH    4
`define CSM_DIV_WIDTH         3

`endif

// *** src/csm_pkg.sv ***
// Types shared by the chip sync and mode config block
`default_nettype none
package csm_pkg;
  typedef enum logic [1:0] {
    CSM_SYNC_DIVRESET  = 2'b01,
    CSM_SYNC_TIMESTAMP = 2'b10
  } csm_sync_mode_t;

  typedef enum logic [1:0] {
    CSM_LINK_UP      = 2'b01,
    CSM_LINK_RECOVER = 2'b10
  } csm_link_state_t;
endpackage
`default_nettype wire

// *** verification/csm_sync_mode_checker.sv ***
// Port assertions for the sync and mode config block
`default_nettype none
module csm_sync_mode_checker #(
  parameter int LINK_RECOVER = 4
) (
  // Watched ports
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sampleValid,
  input wire logic        linkValid,
  input wire logic [13:0] linkQ,
  input wire logic        linkTag,
  input wire logic        linkUp,
  input wire logic [2:0]  divPhase,
  input wire logic        divReset,
  input wire logic        monRestart,
  input wire logic        qIgnore,
  input wire logic        ddcBypass,
  input wire logic [2:0]  decimFactor
);
  int downCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles the link has been down
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      downCnt <= 0;
    else
      downCnt <= linkUp ? 0 : downCnt + 1;
  end
  // Strobe effects on dividers and link
  chk_div_pulse: assert property (divReset |-> monRestart && divPhase == 3'h0 ##1 !divReset)
    else $error("divider reset pulse malformed");
  chk_mon_cause: assert property (monRestart |-> divReset)
    else $error("monitor restart without divider reset");
  chk_drop_cause: assert property ($fell(linkUp) |-> divReset)
    else $error("link dropped without strobe");
  chk_link_hold: assert property ($rose(linkUp) |-> downCnt == LINK_RECOVER)
    else $error("link down span wrong");
  chk_valid_gate: assert property (!linkUp |-> !linkValid)
    else $error("word valid while link down");
  // Output word relations
  chk_tag_word: assert property (linkTag |-> linkValid)
    else $error("tag without valid word");
  chk_word_lat: assert property (linkValid |-> $past(sampleValid, 5))
    else $error("word without sample five cycles before");
  chk_q_drop: assert property (linkValid && $past(qIgnore, 5) |-> linkQ == 14'h0)
    else $error("quadrature not dropped");
  chk_ratio_bypass: assert property (ddcBypass == (decimFactor == 3'h1))
    else $error("bypass disagrees with ratio");
endmodule
`default_nettype wire

// *** verification/csm_sync_mode_regs_test.sv ***
// Self-checking bench for the sync and mode config registers
`default_nettype none
`include "csm_consts.svh"
module csm_sync_mode_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        sysrefPin = 1'b0, sampleValid = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [13:0] sampleI = 14'h0, sampleQ = 14'h0;
  wire logic   hreadyout, hresp, linkValid, linkTag, linkUp, divReset, monRestart;
  wire logic   ddcBypass, qIgnore;
  wire logic [31:0] hrdata;
  wire logic [13:0] linkI, linkQ;
  wire logic [2:0]  divPhase, decimFactor;
  wire logic [3:0]  ddcEnable;
  int          error_cnt = 0, n_tests = 0;

  // Device under test, short link recovery
  csm_sync_mode_regs #(.LINK_RECOVER(4)) uut (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .sysrefPin, .sampleValid, .sampleI, .sampleQ,
    .linkValid, .linkI, .linkQ, .linkTag, .linkUp, .divPhase, .divReset, .monRestart,
    .ddcEnable, .ddcBypass, .qIgnore, .decimFactor
  );

  // Clock
  always #10 clk = ~clk;

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  // One single word transfer
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rc(input logic [11:0] idx, input logic [31:0] e);
    xfer(1'b0, idx, 8'h0);
    chk(rd === e, "read value");
  endtask

  task automatic t_regs;
    chk(ddcBypass === 1'b1 && decimFactor === 3'h1 && ddcEnable === 4'h0, "reset");
    rc(`CSM_IDX_SYNC_MODE, 32'h0);
    rc(`CSM_IDX_CHANNEL_MODE, 32'h0);
    rc(`CSM_IDX_DECIM_RATIO, 32'h0);
    rc(12'h203, 32'h0);
    xfer(1'b1, `CSM_IDX_CHANNEL_MODE, 8'hFF);
    rc(`CSM_IDX_CHANNEL_MODE, 32'h2F);
    chk(qIgnore === 1'b1, "q ignore");
    xfer(1'b1, `CSM_IDX_SYNC_MODE, 8'hFF);
    rc(`CSM_IDX_SYNC_MODE, 32'h1);
  endtask

  task automatic t_codes;
    logic [3:0] dc [5] = '{4'h0, 4'h1, 4'h8, 4'h2, 4'h5};
    logic [3:0] en [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, `CSM_IDX_DECIM_RATIO, {4'h0, dc[k]});
      xfer(1'b1, `CSM_IDX_CHANNEL_MODE, 8'(k % 4));
      #1;
      chk(decimFactor === 3'(k + 1) && ddcBypass === (k == 0), "ratio");
      chk(ddcEnable === en[k % 4], "converter enables");
    end
  endtask

  task automatic t_q(input logic [7:0] m);
    xfer(1'b1, `CSM_IDX_CHANNEL_MODE, m);
    @(posedge clk);
    sampleValid <= 1'b1;
    sampleI <= 14'h1234;
    sampleQ <= 14'h0ABC;
    @(posedge clk);
    sampleValid <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(linkValid === 1'b1 && linkI === 14'h1234, "word latency");
    chk(linkQ === (m[5] ? 14'h0 : 14'h0ABC), "q path");
  endtask

  task automatic t_div;
    logic [2:0] pre = 3'h0;
    logic       drop = 1'b0;
    int         n = 0;
    xfer(1'b1, `CSM_IDX_SYNC_MODE, 8'h0);
    @(posedge clk);
    sysrefPin <= 1'b1;
    do begin
      @(posedge clk);
      #1;
      if (divReset !== 1'b1) pre = divPhase;
      n++;
    end while (divReset !== 1'b1 && n < 10);
    chk(divReset === 1'b1 && monRestart === 1'b1 && divPhase === 3'h0, "div reset");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      sysrefPin <= 1'b0;
      #1;
      if (linkUp !== 1'b1) drop = 1'b1;
    end
    chk(drop === (pre != 3'h0), "link drop");
    repeat (6) @(posedge clk);
    #1;
    chk(linkUp === 1'b1, "link back");
    xfer(1'b0, `CSM_IDX_SYNC_STATUS, 8'h0);
    chk(rd[16:8] === 9'h101, "strobe count");
    chk(rd[7:0] === {5'h00, pre}, "captured phase");
  endtask

  task automatic t_ts;
    int          tags = 0;
    logic [13:0] tv = 14'h0;
    xfer(1'b1, `CSM_IDX_SYNC_MODE, 8'h1);
    for (int n = 0; n < 16; n++) begin
      @(posedge clk);
      sampleValid <= 1'b1;
      sampleI <= 14'(n);
      sysrefPin <= (n == 2);
      #1;
      chk(!divReset && !monRestart && linkUp, "strobe effect");
      if (linkTag === 1'b1) begin
        tags++;
        tv = linkI;
      end
    end
    chk(tags == 1, "tag count");
    chk(tv >= 14'h4 && tv <= 14'h6, "tagged sample");
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_codes;
    t_q(8'h20);
    t_q(8'h00);
    t_div;
    t_ts;
    report_and_stop;
  end

  // Hang guard
  initial begin
    #100us;
    error_cnt++;
    report_and_stop;
  end
endmodule

bind csm_sync_mode_regs csm_sync_mode_checker #(.LINK_RECOVER(LINK_RECOVER)) chk_i (
  .clk, .rst, .sampleValid, .linkValid, .linkQ, .linkTag, .linkUp, .divPhase,
  .divReset, .monRestart, .qIgnore, .ddcBypass, .decimFactor
);
`default_nettype wire
